// File: design/itw_pkg.sv
// Purpose: shared constants and enumerations of the wake-capable target link
// Assumes: host clock 50 MHz; device logic runs on the free link clock
// Notes:   target wake counts are device-clock cycles, host wake counts host-clock cycles; device times are unknown
package itw_pkg;
    // ==========================================================
    // timing
    localparam int CLK_HZ             = 50_000_000;
    localparam int SCL_HZ             = 400_000;
    localparam int QTR_CYC            = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int WAKE_LOW_CYC_DEF   = 64;
    localparam int WAKE_HIGH_CYC_DEF  = 32;
    localparam int HOST_WAKE_HOLD_CYC = 200;
    localparam int HOST_WAKE_WAIT_CYC = 200;
    // ==========================================================
    // byte framing and word address functions
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [3:0] BIT_END  = 4'h9;
    localparam logic [7:0] WA_RESET = 8'h00;
    localparam logic [7:0] WA_SLEEP = 8'h01;
    localparam logic [7:0] WA_IDLE  = 8'h02;
    localparam logic [7:0] WA_CMD   = 8'h03;
    // ==========================================================
    // enumerations
    typedef enum logic [2:0] {
        CMD_WAKE, CMD_START, CMD_WRITE, CMD_READ, CMD_STOP
    } itw_cmd_e;
    typedef enum logic [2:0] {
        ST_SLEEP, ST_IDLE, ST_WLOW, ST_WHIGH, ST_AWAKE, ST_BUSY
    } itw_dev_e;
    typedef enum logic [2:0] {
        H_IDLE, H_WAKE, H_WWAIT, H_SEQ, H_BIT, H_DONE
    } itw_host_e;
endpackage

// File: design/itw_if.sv
// Purpose: two-wire link between host controller and target
// Assumes: external pull-up on the data wire
// Notes:   both ends are open drain on data; clock is push-pull from host
`timescale 1ns/1ps
interface itw_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    // wired-and with pull-up
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (output scl, output host_sda_o, output host_sda_oe,
                  input sda);
endinterface

// File: design/itw_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs idle high
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module itw_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// File: design/itw_target.sv
// Purpose: two-wire target port with low-power wake detector
// Assumes: link_clk runs free and much faster than scl
// Notes:   only acknowledge is ever driven; read data floats high
`timescale 1ns/1ps
// Function
// - asleep, only wake condition is honoured
// - wake on sda rise after long low
// - wait wake-high delay, then honour bus
// - scl ignored asleep, idle, during wake low
// - host wakes by long low or slow zero
// - wake sequence while awake does nothing
// - slow foreign traffic may wake; host resleeps
// - bit is sda sampled while scl high
// - sda fall with scl high is start
// - stop ends transfer, enough bytes start busy
// - host ends every packet with stop
// - receiver pulls sda low on ninth clock
// - high on ninth clock means error/end
// - all seven address bits configurable
// - data output open drain only
// - host releases data while device drives
// - scl input only, host keeps defined
// - works at scl up to 1 MHz
// - address bits 7..1 match, bit0 write
// - second byte selects reset/sleep/idle/command
module itw_target
    import itw_pkg::*;
#(
    parameter int WAKE_LOW_CYC  = WAKE_LOW_CYC_DEF,
    parameter int WAKE_HIGH_CYC = WAKE_HIGH_CYC_DEF
) (
    input  wire logic       link_clk,
    input  wire logic       rst,
    itw_if.dev              bus,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       exec_done,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            exec_start,
    output logic            busy,
    output logic            awake
);
    localparam logic [15:0] WL_LAST = 16'(WAKE_LOW_CYC - 1);
    localparam logic [15:0] WH_LAST = 16'(WAKE_HIGH_CYC - 1);

    // ==========================================================
    // pin sampling
    logic [1:0]  pin_s;
    logic        scl_s;
    logic        sda_s;
    logic        scl_q_reg;
    logic        sda_q_reg;
    logic        start_ev;
    logic        stop_ev;
    logic        scl_rise;
    logic        scl_fall;
    logic        on_bus;
    itw_dev_e    st_reg;
    logic        lp_idle_reg;
    logic [15:0] wcnt_reg;
    logic        in_xfer_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic        ack_oe_reg;
    logic [1:0]  byte_idx_reg;
    logic        sel_reg;
    logic        rw_reg;
    logic [7:0]  func_reg;
    logic        func_ok_reg;
    logic [7:0]  len_reg;
    logic [7:0]  fill_reg;
    logic        ack_now;
    logic        byte_done;
    logic        store_ev;
    logic        exec_go;
    logic        sleep_go;
    logic        idle_go;

    // sync delay is two link clocks, far below a 1 MHz quarter bit
    itw_sync #(.WIDTH(2)) u_sync (
        .clk (link_clk),
        .rst (rst),
        .d   ({bus.scl, bus.sda}),
        .q   (pin_s)
    );
    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    // scl is only looked at while awake or busy
    assign on_bus   = (st_reg == ST_AWAKE) || (st_reg == ST_BUSY);
    assign start_ev = on_bus && scl_s && scl_q_reg
                      && sda_q_reg && !sda_s;
    assign stop_ev  = on_bus && scl_s && scl_q_reg
                      && !sda_q_reg && sda_s;
    assign scl_rise = scl_s && !scl_q_reg;
    assign scl_fall = !scl_s && scl_q_reg;

    // ==========================================================
    // power and wake state
    assign exec_go  = in_xfer_reg && sel_reg && (st_reg == ST_AWAKE)
                      && (fill_reg != 8'h00) && (fill_reg >= len_reg);
    assign sleep_go = in_xfer_reg && func_ok_reg && (func_reg == WA_SLEEP);
    assign idle_go  = in_xfer_reg && func_ok_reg && (func_reg == WA_IDLE);

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            st_reg      <= ST_SLEEP;
            lp_idle_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                ST_SLEEP, ST_IDLE: begin
                    if (!sda_s) begin
                        st_reg <= ST_WLOW;
                    end
                end
                ST_WLOW: begin
                    if (sda_s) begin
                        if (wcnt_reg == WL_LAST) begin
                            st_reg <= ST_WHIGH;
                        end else if (lp_idle_reg) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            st_reg <= ST_SLEEP;
                        end
                    end
                end
                ST_WHIGH: begin
                    if (wcnt_reg == WH_LAST) begin
                        st_reg <= ST_AWAKE;
                    end
                end
                // no wake detection here: a long low is just bus traffic
                ST_AWAKE: begin
                    if (stop_ev && exec_go) begin
                        st_reg <= ST_BUSY;
                    end else if (stop_ev && sleep_go) begin
                        st_reg      <= ST_SLEEP;
                        lp_idle_reg <= 1'b0;
                    end else if (stop_ev && idle_go) begin
                        st_reg      <= ST_IDLE;
                        lp_idle_reg <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    if (exec_done) begin
                        st_reg <= ST_AWAKE;
                    end
                end
            endcase
        end
    end

    // low time saturates so a very long low still wakes on release
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            wcnt_reg <= 16'h0000;
        end else if (st_reg == ST_WLOW) begin
            if (sda_s) begin
                wcnt_reg <= 16'h0000;
            end else if (wcnt_reg != WL_LAST) begin
                wcnt_reg <= wcnt_reg + 16'h0001;
            end
        end else if (st_reg == ST_WHIGH) begin
            wcnt_reg <= wcnt_reg + 16'h0001;
        end else begin
            wcnt_reg <= 16'h0000;
        end
    end

    // ==========================================================
    // bit framing and acknowledge
    assign byte_done = in_xfer_reg && scl_fall && (bit_cnt_reg == BIT_ACK);

    always_comb begin
        ack_now = 1'b0;
        unique case (byte_idx_reg)
            2'd0: ack_now = (shift_reg[7:1] == cfg_addr[7:1])
                            && (st_reg == ST_AWAKE);
            2'd1: ack_now = sel_reg && !rw_reg
                            && (shift_reg <= WA_CMD);
            default: ack_now = sel_reg && !rw_reg;
        endcase
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            in_xfer_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            ack_oe_reg  <= 1'b0;
        end else if (!on_bus) begin
            in_xfer_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            ack_oe_reg  <= 1'b0;
        end else if (start_ev) begin
            in_xfer_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            ack_oe_reg  <= 1'b0;
        end else if (stop_ev) begin
            in_xfer_reg <= 1'b0;
            ack_oe_reg  <= 1'b0;
        end else if (in_xfer_reg) begin
            if (scl_rise && (bit_cnt_reg < BIT_ACK)) begin
                shift_reg <= {shift_reg[6:0], sda_s};
            end
            if (scl_rise && (bit_cnt_reg != BIT_END)) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && (bit_cnt_reg == BIT_END)) begin
                bit_cnt_reg <= 4'h0;
                ack_oe_reg  <= 1'b0;
            end
            if (byte_done) begin
                ack_oe_reg <= ack_now;
            end
        end
    end

    // open drain: output level is fixed low, only the enable moves
    assign bus.dev_sda_o  = 1'b0;
    assign bus.dev_sda_oe = ack_oe_reg;

    // ==========================================================
    // byte decode
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            byte_idx_reg <= 2'd0;
            sel_reg      <= 1'b0;
            rw_reg       <= 1'b0;
            func_reg     <= WA_CMD;
            func_ok_reg  <= 1'b0;
        end else if (!on_bus || start_ev) begin
            byte_idx_reg <= 2'd0;
            sel_reg      <= 1'b0;
            func_ok_reg  <= 1'b0;
        end else if (byte_done) begin
            if (byte_idx_reg != 2'd2) begin
                byte_idx_reg <= byte_idx_reg + 2'd1;
            end
            if (byte_idx_reg == 2'd0) begin
                sel_reg <= ack_now;
                rw_reg  <= shift_reg[0];
            end else if ((byte_idx_reg == 2'd1) && ack_now) begin
                func_reg    <= shift_reg;
                func_ok_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // command input buffer bookkeeping; first byte is the count
    assign store_ev = byte_done && (byte_idx_reg == 2'd2) && sel_reg
                      && !rw_reg && func_ok_reg && (func_reg == WA_CMD)
                      && ((fill_reg == 8'h00) || (fill_reg < len_reg));

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            len_reg  <= 8'h00;
            fill_reg <= 8'h00;
        end else if (!on_bus || (stop_ev && exec_go)) begin
            fill_reg <= 8'h00;
        end else if (byte_done && (byte_idx_reg == 2'd1) && ack_now
                     && (shift_reg == WA_RESET)) begin
            fill_reg <= 8'h00;
        end else if (store_ev) begin
            if (fill_reg == 8'h00) begin
                len_reg <= shift_reg;
            end
            fill_reg <= fill_reg + 8'h01;
        end
    end

    // ==========================================================
    // user side outputs
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            rx_data    <= 8'h00;
            rx_valid   <= 1'b0;
            exec_start <= 1'b0;
            busy       <= 1'b0;
            awake      <= 1'b0;
        end else begin
            rx_valid   <= store_ev;
            exec_start <= stop_ev && exec_go;
            busy       <= (st_reg == ST_BUSY);
            awake      <= on_bus;
            if (store_ev) begin
                rx_data <= shift_reg;
            end
        end
    end
endmodule

// File: design/itw_host.sv
// Purpose: host-side bus controller issuing wake, start, byte and stop
// Assumes: one command at a time on a valid/ready port
// Notes:   scl made by a quarter-bit divider of clk
`timescale 1ns/1ps
module itw_host
    import itw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    itw_if.host             bus,
    input  wire logic       cmd_valid,
    input  itw_cmd_e        cmd_kind,
    input  wire logic [7:0] cmd_data,
    output logic            cmd_ready,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    output logic            rsp_ack
);
    localparam logic [15:0] QTR_LAST  = 16'(QTR_CYC - 1);
    localparam logic [15:0] HOLD_LAST = 16'(HOST_WAKE_HOLD_CYC - 1);
    localparam logic [15:0] WAIT_LAST = 16'(HOST_WAKE_WAIT_CYC - 1);

    itw_host_e   st_reg;
    itw_cmd_e    kind_reg;
    logic [15:0] cnt_reg;
    logic [1:0]  q_reg;
    logic [3:0]  bit_reg;
    logic        ack_tx_reg;
    logic        scl_reg;
    logic        oe_reg;
    logic        sda_s;
    logic        tick;
    logic        wrap;

    itw_sync #(.WIDTH(1)) u_sync (
        .clk (clk),
        .rst (rst),
        .d   (bus.sda),
        .q   (sda_s)
    );

    // ==========================================================
    // quarter-bit timer
    assign tick = (cnt_reg == QTR_LAST);
    assign wrap = (tick && ((st_reg == H_SEQ) || (st_reg == H_BIT)))
                  || ((st_reg == H_WAKE) && (cnt_reg == HOLD_LAST));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
        end else if ((st_reg == H_IDLE) || (st_reg == H_DONE) || wrap) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // ==========================================================
    // sequencer; sda only moves in quarter 1 or 3 while scl is steady
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg     <= H_IDLE;
            kind_reg   <= CMD_WAKE;
            q_reg      <= 2'd0;
            bit_reg    <= 4'h0;
            ack_tx_reg <= 1'b0;
            rsp_data   <= 8'h00;
            scl_reg    <= 1'b1;
            oe_reg     <= 1'b0;
            cmd_ready  <= 1'b1;
            rsp_valid  <= 1'b0;
            rsp_ack    <= 1'b0;
        end else begin
            unique case (st_reg)
                H_IDLE: begin
                    rsp_valid <= 1'b0;
                    if (cmd_valid) begin
                        cmd_ready  <= 1'b0;
                        kind_reg   <= cmd_kind;
                        rsp_data   <= cmd_data;
                        ack_tx_reg <= cmd_data[0];
                        bit_reg    <= 4'h0;
                        q_reg      <= 2'd0;
                        if (cmd_kind == CMD_WAKE) begin
                            oe_reg <= 1'b1;
                            st_reg <= H_WAKE;
                        end else begin
                            scl_reg <= 1'b0;
                            st_reg  <= ((cmd_kind == CMD_START)
                                        || (cmd_kind == CMD_STOP))
                                       ? H_SEQ : H_BIT;
                        end
                    end
                end
                // slow foreign traffic may wake the target; software
                // follows it with a sleep or idle sequence
                H_WAKE: begin
                    if (cnt_reg == HOLD_LAST) begin
                        oe_reg <= 1'b0;
                        st_reg <= H_WWAIT;
                    end
                end
                H_WWAIT: begin
                    if (cnt_reg == WAIT_LAST) begin
                        st_reg <= H_DONE;
                    end
                end
                H_SEQ: begin
                    if (tick) begin
                        q_reg <= q_reg + 2'd1;
                        unique case (q_reg)
                            2'd0: oe_reg  <= (kind_reg == CMD_STOP);
                            2'd1: scl_reg <= 1'b1;
                            2'd2: oe_reg  <= (kind_reg == CMD_START);
                            2'd3: st_reg  <= H_DONE;
                        endcase
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        q_reg <= q_reg + 2'd1;
                        unique case (q_reg)
                            2'd0: begin
                                // released while the target acknowledges
                                if (bit_reg == BIT_ACK) begin
                                    oe_reg <= (kind_reg == CMD_READ)
                                              && ack_tx_reg;
                                end else begin
                                    oe_reg <= (kind_reg == CMD_WRITE)
                                              && !rsp_data[7];
                                end
                            end
                            2'd1: scl_reg <= 1'b1;
                            2'd2: begin
                            end
                            2'd3: begin
                                if (bit_reg == BIT_ACK) begin
                                    rsp_ack <= !sda_s;
                                    st_reg  <= H_DONE;
                                end else begin
                                    rsp_data <= {rsp_data[6:0], sda_s};
                                    bit_reg  <= bit_reg + 4'h1;
                                    scl_reg  <= 1'b0;
                                end
                            end
                        endcase
                    end
                end
                H_DONE: begin
                    rsp_valid <= 1'b1;
                    cmd_ready <= 1'b1;
                    st_reg    <= H_IDLE;
                end
            endcase
        end
    end

    assign bus.scl         = scl_reg;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = oe_reg;
endmodule

// File: verification/itw_assertions.sv
// Purpose: wire-level checks of the two-wire link
// Assumes: sampled on the target's link clock
// Notes:   scl is sampled asynchronously; bounds leave slack for that
`timescale 1ns/1ps
module itw_assertions (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    // ======================================
    // frame tracking on the raw wires
    logic       scl_q;
    logic       sda_q;
    logic       framed;
    logic [3:0] bits_seen;

    // clock rises since start, wrapping after the ninth clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            framed    <= 1'b0;
            bits_seen <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda_q && !sda) begin
                framed    <= 1'b1;
                bits_seen <= 4'h0;
            end else if (scl && scl_q && !sda_q && sda) begin
                framed <= 1'b0;
            end else if (scl && !scl_q) begin
                bits_seen <= (bits_seen == 4'h9) ? 4'h1 : bits_seen + 4'h1;
            end
        end
    end

    // ======================================
    // wire checks
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (rst);

    dev_od_a: assert property (dev_sda_oe |-> !dev_sda_o)
        else $error("device drives data high");
    host_od_a: assert property (host_sda_oe |-> !host_sda_o)
        else $error("host drives data high");
    ack_low_a: assert property (dev_sda_oe |-> !sda)
        else $error("acknowledge does not pull data low");
    ack_start_a: assert property ($rose(dev_sda_oe) |-> !scl)
        else $error("device data changed with clock high");
    hold_high_a: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data moved while clock high");
    ack_clock_a: assert property (
        $rose(dev_sda_oe) |-> ##[1:100] $rose(scl))
        else $error("no ninth clock during acknowledge");
    ack_end_a: assert property (
        $rose(dev_sda_oe) |-> ##[1:200] $fell(dev_sda_oe))
        else $error("acknowledge never released");
    ack_framed_a: assert property ($rose(dev_sda_oe) |-> framed)
        else $error("acknowledge outside a framed transfer");
    ack_ninth_a: assert property (
        $rose(dev_sda_oe) |-> (bits_seen == 4'h8))
        else $error("acknowledge not after the eighth bit");
endmodule

// File: verification/i2c_target_with_wake_bench.sv
// Purpose: host and target joined over the link, self-checking
// Assumes: target address byte 8'haa, default wake counts
// Notes:   host answers and stored bytes are checked against queues
`timescale 1ns/1ps
module i2c_target_with_wake_bench import itw_pkg::*; ;
    logic       clk = 1'b0;
    logic       link_clk = 1'b1;
    logic       rst = 1'b1;
    logic       cmd_valid = 1'b0;
    itw_cmd_e   cmd_kind = CMD_STOP;
    logic [7:0] cmd_data = 8'h00;
    logic       exec_done = 1'b0;
    logic       cmd_ready, rsp_valid, rsp_ack, rx_valid, exec_start, busy, awake;
    logic [7:0] rsp_data, rx_data, r1, r2;
    logic [7:0] cfg_addr = 8'haa;
    logic [9:0] he;
    logic [9:0] hq[$];
    logic [7:0] dq[$];
    int         fail_count = 0, samples_checked = 0, ex_n = 0;
    int         seed = 32'h5cec2f3f;

    always #10 clk = ~clk;
    always #24 link_clk = ~link_clk;

    itw_if lnk();
    itw_host itw_host_i(.clk(clk), .rst(rst), .bus(lnk),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    itw_target itw_target_i(.link_clk(link_clk), .rst(rst), .bus(lnk),
        .cfg_addr(cfg_addr), .exec_done(exec_done), .rx_data(rx_data),
        .rx_valid(rx_valid), .exec_start(exec_start), .busy(busy),
        .awake(awake));
    itw_assertions itw_assertions_i(.link_clk(link_clk), .rst(rst),
        .scl(lnk.scl), .host_sda_o(lnk.host_sda_o),
        .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o),
        .dev_sda_oe(lnk.dev_sda_oe), .sda(lnk.sda));

    // ======================================
    // compare, drive and verdict
    task automatic cmp(string w, logic [7:0] g, logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
        end
    endtask

    task automatic cmd(itw_cmd_e k, logic [7:0] d, logic [9:0] e);
        hq.push_back(e);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_data = d;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        @(negedge clk);
        cmd_valid = 1'b0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
    endtask

    task automatic wr(logic [7:0] d, logic a);
        cmd(CMD_WRITE, d, {1'b1, a, d});
    endtask

    task automatic op(itw_cmd_e k);
        cmd(k, 8'h00, 10'h000);
    endtask

    // start, one address byte, stop
    task automatic probe(logic [7:0] ad, logic a);
        op(CMD_START);
        wr(ad, a);
        op(CMD_STOP);
    endtask

    task automatic give_verdict;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ======================================
    // monitors
    always @(posedge clk) begin
        if (rsp_valid === 1'b1 && hq.size() > 0) begin
            he = hq.pop_front();
            cmp("rsp data", rsp_data, he[7:0]);
            if (he[9]) cmp("ack", {7'h00, rsp_ack}, {7'h00, he[8]});
        end
    end

    always @(posedge link_clk) begin
        if (exec_start === 1'b1) ex_n++;
        if (rx_valid === 1'b1) cmp("rx", rx_data, dq.size() > 0 ? dq.pop_front() : 8'hxx);
    end

    // ======================================
    // scenarios
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        r1 = 8'($random(seed));
        r2 = 8'($random(seed));
        probe(8'haa, 1'b0);
        cmp("awake", {7'h00, awake}, 8'h00);
        $display("asleep test done");
        op(CMD_WAKE);
        cmp("awake", {7'h00, awake}, 8'h01);
        // partial command, then a pointer reset that must discard it
        dq = {8'h03, r1};
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h03, 1'b1);
        wr(8'h03, 1'b1);
        wr(r1, 1'b1);
        op(CMD_STOP);
        cmp("busy", {7'h00, busy}, 8'h00);
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h00, 1'b1);
        op(CMD_STOP);
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h03, 1'b1);
        dq = {8'h03, r1, r2};
        wr(8'h03, 1'b1);
        wr(r1, 1'b1);
        wr(r2, 1'b1);
        op(CMD_STOP);
        repeat (4) @(negedge link_clk);
        cmp("busy", {7'h00, busy}, 8'h01);
        probe(8'haa, 1'b0);
        @(negedge link_clk) exec_done = 1'b1;
        @(negedge link_clk) exec_done = 1'b0;
        $display("command test done");
        op(CMD_WAKE);
        probe(8'haa ^ {r1[6:0] | 7'h01, 1'b0}, 1'b0);
        @(negedge clk) cfg_addr = {r2[7:1], 1'b1};
        probe({r2[7:1], 1'b0}, 1'b1);
        @(negedge clk) cfg_addr = 8'haa;
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h04, 1'b0);
        op(CMD_STOP);
        $display("address test done");
        op(CMD_START);
        wr(8'hab, 1'b1);
        cmd(CMD_READ, 8'h01, {2'b11, 8'hff});
        cmd(CMD_READ, 8'h00, {2'b10, 8'hff});
        op(CMD_STOP);
        $display("read test done");
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h02, 1'b1);
        op(CMD_STOP);
        cmp("awake", {7'h00, awake}, 8'h00);
        op(CMD_WAKE);
        cmp("awake", {7'h00, awake}, 8'h01);
        $display("idle test done");
        op(CMD_START);
        wr(8'haa, 1'b1);
        wr(8'h01, 1'b1);
        op(CMD_STOP);
        probe(8'haa, 1'b0);
        cmp("awake", {7'h00, awake}, 8'h00);
        $display("sleep test done");
        cmp("exec", 8'(ex_n), 8'h01);
        cmp("rx left", 8'(dq.size()), 8'h00);
        give_verdict();
    end

    // ======================================
    // watchdog, well past the expected run
    initial begin
        #1_500_000;
        fail_count++;
        give_verdict();
    end
endmodule
